// File: logic/acp_cfg_if.sv
/*
  Carrier between the port top and its serial register file.
  Assumes all signals are on the system clock, pins already synchronised.
*/
`timescale 1ns/1ps
interface acp_cfg_if;
  logic       strap;
  logic       csN;
  logic       sck;
  logic       sdi;
  logic       sdoPull;
  logic [7:0] regPower;
  logic [7:0] regStabilizer;
  logic [7:0] regOutput;

  modport port (input strap, csN, sck, sdi,
                output sdoPull, regPower, regStabilizer, regOutput);
  modport core (output strap, csN, sck, sdi,
                input sdoPull, regPower, regStabilizer, regOutput);
endinterface

// File: logic/acp_pkg.sv
/*
  Constants for the converter configuration and output port: serial mode
  register map, field positions, reset values and pipeline latencies.
  Assumes a single 10 MHz system clock samples every pin of the port.
*/
// What this block does
// - Strap low turns select, clock, data-in and data-out into a serial port.
// - Strap high makes select, clock and data-in plain static mode inputs.
// - Serial bits shift into mode registers only while select is low.
// - Each serial data bit is taken on the serial clock rising edge.
// - Data-out is only ever pulled low; a pull-up makes it high.
// - Parallel mode: select low turns stabilizer off, high turns it on.
// - Parallel mode: clock low gives full-rate output, high double-rate high-drive.
// - Parallel mode: data-in low runs normally, high enters sleep.
// - Parallel mode never drives data-out.
// - Conversion starts on positive encode rising, negative encode falling.
// - Full-rate mode gives fourteen parallel bits, bit thirteen most significant.
// - Full-rate data changes on forwarded clock falling edge by default.
// - Forwarded clock phase can be delayed by a mode register setting.
// - Negative forwarded clock is always the inverse of the positive one.
// - Range flag is high for any word whose input left the range.
// - Double-rate lanes show even bits while clock low, odd while high.
// - Serial mode stabilizer comes from a bit of the stabilizer register.
package acp_pkg;

  // --------------------------------------------------------------------
  // Serial register map
  // --------------------------------------------------------------------
  localparam int         REG_COUNT       = 5;
  localparam logic [6:0] ADDR_RESET      = 7'h00;
  localparam logic [6:0] ADDR_POWER      = 7'h01;
  localparam logic [6:0] ADDR_STABILIZER = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT     = 7'h03;
  localparam logic [6:0] ADDR_FORMAT     = 7'h04;

  // Field positions
  localparam int BIT_SOFT_RESET  = 7;
  localparam int BIT_SLEEP       = 0;
  localparam int BIT_STABILIZER  = 0;
  localparam int BIT_PHASE_LO    = 1;
  localparam int BIT_HIGH_DRIVE  = 4;
  localparam int BIT_MODE_LO     = 0;

  // Reset values
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // --------------------------------------------------------------------
  // Frame and timing counts
  // --------------------------------------------------------------------
  localparam int         FRAME_BITS   = 16;
  localparam logic [4:0] HEADER_LAST  = 5'h07;
  localparam logic [4:0] FRAME_LAST   = 5'h0F;
  localparam int         LATENCY_FULL = 5;
  localparam int         PIPE_DEPTH   = 6;
  localparam int         PHASE_TAPS   = 4;
  localparam int         SAMPLE_WIDTH = 14;
  localparam int         LANES        = 7;

  typedef enum logic [1:0] {
    OUT_FULL_CMOS,
    OUT_DDR_CMOS,
    OUT_DDR_LVDS
  } acp_out_mode_t;

endpackage

// File: logic/acp_port_top.sv
/*
  Digital side of a 14-bit sampling converter: configuration pins, output
  word pipeline, forwarded output clock and range flag.
  Assumes the conversion core hands a word and range bit on each encode
  edge, and all pins are asynchronous to the 10 MHz system clock.
*/
`timescale 1ns/1ps
module acp_port_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Configuration pins
  input  wire logic        configPathStrap,
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdoOut,
  output logic             sdoOeN,
  // Encode inputs and conversion core
  input  wire logic        sampleClockPos,
  input  wire logic        sampleClockNeg,
  input  wire logic [13:0] coreWord,
  input  wire logic        coreOverRange,
  // Output port
  output logic [13:0]      sampleBits,
  output logic             rangeFlag,
  output logic             fwdOutClockPos,
  output logic             fwdOutClockNeg,
  // Mode status
  output logic             stabilizerOn,
  output logic             sleepMode,
  output logic [1:0]       outputMode,
  output logic             lvdsHighDrive
);

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  assign pinRaw = {configPathStrap, csN, sck, sdi,
                   sampleClockPos, sampleClockNeg};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : gSync
      // Two flops per pin; only the second is read downstream
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
        end else begin
          syncA[g] <= pinRaw[g];
          syncB[g] <= syncA[g];
        end
      end
    end
  endgenerate

  logic strapS, csS, sckS, sdiS, encLevel;
  assign strapS   = syncB[5];
  assign csS      = syncB[4];
  assign sckS     = syncB[3];
  assign sdiS     = syncB[2];
  assign encLevel = syncB[1] && !syncB[0];

  // -------------------------------------------------------------------
  // Serial register file
  // -------------------------------------------------------------------
  acp_cfg_if cfg ();
  assign cfg.strap = strapS;
  assign cfg.csN   = csS;
  assign cfg.sck   = sckS;
  assign cfg.sdi   = sdiS;

  acp_serial_regs uRegs (
    .clk    (clk),
    .resetn (resetn),
    .cfg    (cfg.port)
  );

  // -------------------------------------------------------------------
  // Mode selection
  // -------------------------------------------------------------------
  acp_pkg::acp_out_mode_t modeSel;
  logic       stabSel, sleepSel, driveSel;
  logic [1:0] phaseSel;
  always_comb begin
    if (strapS) begin
      // Static pins give the reduced mode set
      stabSel  = csS;
      modeSel  = sckS ? acp_pkg::OUT_DDR_LVDS
                      : acp_pkg::OUT_FULL_CMOS;
      driveSel = sckS;
      sleepSel = sdiS;
      phaseSel = 2'h0;
    end else begin
      stabSel  = cfg.regStabilizer[acp_pkg::BIT_STABILIZER];
      phaseSel = cfg.regStabilizer[acp_pkg::BIT_PHASE_LO +: 2];
      driveSel = cfg.regOutput[acp_pkg::BIT_HIGH_DRIVE];
      sleepSel = cfg.regPower[acp_pkg::BIT_SLEEP];
      case (cfg.regOutput[acp_pkg::BIT_MODE_LO +: 2])
        2'h1:    modeSel = acp_pkg::OUT_DDR_CMOS;
        2'h2:    modeSel = acp_pkg::OUT_DDR_LVDS;
        default: modeSel = acp_pkg::OUT_FULL_CMOS;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Conversion pipeline and output lanes
  // -------------------------------------------------------------------
  logic        encPrev;
  logic [14:0] pipe      [acp_pkg::PIPE_DEPTH];
  logic [14:0] next_pipe [acp_pkg::PIPE_DEPTH];
  logic [14:0] ddrWord, next_ddrWord;
  logic [13:0] next_sampleBits;
  logic        next_rangeFlag;
  logic [acp_pkg::PHASE_TAPS-1:0] clkTap, next_clkTap;
  logic        next_fwdPos;
  logic        encRise, encFall, isFull;

  assign encRise = encLevel && !encPrev;
  assign encFall = !encLevel && encPrev;
  assign isFull  = modeSel == acp_pkg::OUT_FULL_CMOS;

  // Puts even bits (low clock) or odd bits (high clock) on the lanes
  function automatic logic [13:0] laneBits(input logic [13:0] w,
                                           input logic oddHalf);
    logic [13:0] r;
    r = 14'h0000;
    for (int i = 0; i < acp_pkg::LANES; i++) begin
      r[i] = oddHalf ? w[2*i+1] : w[2*i];
    end
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < acp_pkg::PIPE_DEPTH; i++) begin
      next_pipe[i] = pipe[i];
    end
    next_ddrWord    = ddrWord;
    next_sampleBits = sampleBits;
    next_rangeFlag  = rangeFlag;
    if (sleepSel) begin
      // Sleep stops conversion and parks the data bits and range flag low
      next_sampleBits = 14'h0000;
      next_rangeFlag  = 1'b0;
    end else if (encRise) begin
      next_pipe[0] = {coreOverRange, coreWord};
      for (int i = 1; i < acp_pkg::PIPE_DEPTH; i++) begin
        next_pipe[i] = pipe[i-1];
      end
      if (isFull) begin
        // Word sampled five rises ago, all bits in parallel
        next_sampleBits = pipe[acp_pkg::LATENCY_FULL-1][13:0];
        next_rangeFlag  = pipe[acp_pkg::LATENCY_FULL-1][14];
      end else begin
        next_sampleBits = laneBits(ddrWord[13:0], 1'b1);
      end
    end else if (encFall && !isFull) begin
      // Half a cycle later than full rate, even bits first
      next_ddrWord    = pipe[acp_pkg::PIPE_DEPTH-1];
      next_sampleBits = laneBits(pipe[acp_pkg::PIPE_DEPTH-1][13:0], 1'b0);
      next_rangeFlag  = pipe[acp_pkg::PIPE_DEPTH-1][14];
    end
  end

  // Forwarded clock: inverted encode in full rate so data moves on its
  // falling edge; delayed by the phase setting in system clock steps
  always_comb begin
    next_clkTap = {clkTap[acp_pkg::PHASE_TAPS-2:0],
                   isFull ? !encLevel : encLevel};
    next_fwdPos = sleepSel ? 1'b0 : next_clkTap[phaseSel];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      encPrev        <= 1'b0;
      ddrWord        <= 15'h0000;
      sampleBits     <= 14'h0000;
      rangeFlag      <= 1'b0;
      clkTap         <= 4'h0;
      fwdOutClockPos <= 1'b0;
      fwdOutClockNeg <= 1'b1;
      for (int i = 0; i < acp_pkg::PIPE_DEPTH; i++) begin
        pipe[i] <= 15'h0000;
      end
    end else begin
      encPrev        <= encLevel;
      ddrWord        <= next_ddrWord;
      sampleBits     <= next_sampleBits;
      rangeFlag      <= next_rangeFlag;
      clkTap         <= next_clkTap;
      fwdOutClockPos <= next_fwdPos;
      fwdOutClockNeg <= !next_fwdPos;
      for (int i = 0; i < acp_pkg::PIPE_DEPTH; i++) begin
        pipe[i] <= next_pipe[i];
      end
    end
  end

  // -------------------------------------------------------------------
  // Status and open-drain data-out
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stabilizerOn  <= 1'b0;
      sleepMode     <= 1'b0;
      outputMode    <= 2'h0;
      lvdsHighDrive <= 1'b0;
      sdoOut        <= 1'b0;
      sdoOeN        <= 1'b1;
    end else begin
      stabilizerOn  <= stabSel;
      sleepMode     <= sleepSel;
      outputMode    <= modeSel;
      lvdsHighDrive <= driveSel;
      sdoOut        <= 1'b0;
      sdoOeN        <= !(cfg.sdoPull && !strapS);
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence sEncRiseAwake;
    encRise && !sleepSel && isFull;
  endsequence

  AST_CLK_INVERSE: assert property (@(posedge clk) disable iff (!resetn)
    fwdOutClockNeg == !fwdOutClockPos)
    else $error("negative forwarded clock not inverse");
  AST_SDO_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!resetn)
    !sdoOut)
    else $error("data-out driven high");
  AST_PAR_SDO_FREE: assert property (@(posedge clk) disable iff (!resetn)
    $past(strapS) |-> sdoOeN)
    else $error("data-out driven in parallel mode");
  AST_PAR_STAB: assert property (@(posedge clk) disable iff (!resetn)
    strapS |=> stabilizerOn == $past(csS))
    else $error("stabilizer does not follow select");
  AST_PAR_MODE: assert property (@(posedge clk) disable iff (!resetn)
    strapS && sckS |=> outputMode == acp_pkg::OUT_DDR_LVDS && lvdsHighDrive)
    else $error("parallel double-rate mode not selected");
  AST_PAR_SLEEP: assert property (@(posedge clk) disable iff (!resetn)
    strapS |=> sleepMode == $past(sdiS))
    else $error("sleep does not follow data-in");
  AST_FULL_LATENCY: assert property (@(posedge clk) disable iff (!resetn)
    sEncRiseAwake |=> sampleBits == $past(pipe[4][13:0]))
    else $error("full-rate word not five cycles old");
  AST_RANGE_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    sEncRiseAwake |=> rangeFlag == $past(pipe[4][14]))
    else $error("range flag does not match its word");
  AST_SER_STAB: assert property (@(posedge clk) disable iff (!resetn)
    !strapS |=> stabilizerOn == $past(cfg.regStabilizer[0]))
    else $error("serial stabilizer not from register");

endmodule

// File: logic/acp_serial_regs.sv
/*
  Serial mode register file: 16-bit frames, read flag then 7-bit address,
  then 8 data bits, most significant first.
  Assumes synchronised pin levels arrive through the carrier.
*/
`timescale 1ns/1ps
module acp_serial_regs (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   resetn,
  // Pins and registers
  acp_cfg_if.port     cfg
);

  logic       sckPrev;
  logic [4:0] bitCount;
  logic [15:0] shiftIn;
  logic [7:0] outByte;
  logic       reading;
  logic       sdoPull;
  logic [7:0] regs [acp_pkg::REG_COUNT];
  logic [4:0] next_bitCount;
  logic [15:0] next_shiftIn;
  logic [7:0] next_outByte;
  logic       next_reading;
  logic       next_sdoPull;
  logic [7:0] next_regs [acp_pkg::REG_COUNT];
  logic       active;
  logic       sckRise;
  logic       sckFall;
  logic [15:0] frame;

  assign active  = !cfg.strap && !cfg.csN;
  assign sckRise = cfg.sck && !sckPrev;
  assign sckFall = !cfg.sck && sckPrev;
  assign frame   = {shiftIn[14:0], cfg.sdi};

  // -------------------------------------------------------------------
  // Frame decode and register update
  // -------------------------------------------------------------------
  always_comb begin
    next_bitCount = bitCount;
    next_shiftIn  = shiftIn;
    next_outByte  = outByte;
    next_reading  = reading;
    next_sdoPull  = sdoPull;
    for (int i = 0; i < acp_pkg::REG_COUNT; i++) begin
      next_regs[i] = regs[i];
    end
    if (!active) begin
      // Idle select ends any frame and releases the open-drain line
      next_bitCount = 5'h00;
      next_reading  = 1'b0;
      next_sdoPull  = 1'b0;
    end else if (sckRise) begin
      next_shiftIn  = frame;
      next_bitCount = bitCount + 5'h01;
      if (bitCount == acp_pkg::HEADER_LAST) begin
        next_reading = frame[7];
        if (frame[6:0] < 7'(acp_pkg::REG_COUNT)) begin
          next_outByte = regs[frame[2:0]];
        end else begin
          next_outByte = 8'hFF; // Unmapped reads release the line
        end
      end
      if (bitCount == acp_pkg::FRAME_LAST) begin
        next_bitCount = 5'h00;
        if (!frame[15] && frame[14:8] == acp_pkg::ADDR_RESET &&
            frame[acp_pkg::BIT_SOFT_RESET]) begin
          for (int i = 0; i < acp_pkg::REG_COUNT; i++) begin
            next_regs[i] = acp_pkg::RESET_VALUE;
          end
        end else if (!frame[15] &&
                     frame[14:8] < 7'(acp_pkg::REG_COUNT) &&
                     frame[14:8] != acp_pkg::ADDR_RESET) begin
          next_regs[frame[10:8]] = frame[7:0];
        end
      end
    end else if (sckFall && reading) begin
      // Bit is presented on the falling edge for host capture
      next_sdoPull = !outByte[7];
      next_outByte = {outByte[6:0], 1'b1};
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sckPrev  <= 1'b0;
      bitCount <= 5'h00;
      shiftIn  <= 16'h0000;
      outByte  <= 8'hFF;
      reading  <= 1'b0;
      sdoPull  <= 1'b0;
      for (int i = 0; i < acp_pkg::REG_COUNT; i++) begin
        regs[i] <= acp_pkg::RESET_VALUE;
      end
    end else begin
      sckPrev  <= cfg.sck;
      bitCount <= next_bitCount;
      shiftIn  <= next_shiftIn;
      outByte  <= next_outByte;
      reading  <= next_reading;
      sdoPull  <= next_sdoPull;
      for (int i = 0; i < acp_pkg::REG_COUNT; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  assign cfg.sdoPull       = sdoPull;
  assign cfg.regPower      = regs[acp_pkg::ADDR_POWER[2:0]];
  assign cfg.regStabilizer = regs[acp_pkg::ADDR_STABILIZER[2:0]];
  assign cfg.regOutput     = regs[acp_pkg::ADDR_OUTPUT[2:0]];

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  AST_IDLE_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.csN || cfg.strap) |=> $stable(regs[2]) && $stable(regs[3]))
    else $error("registers changed while port idle");
  AST_SHIFT_ON_RISE: assert property (@(posedge clk) disable iff (!resetn)
    (active && sckRise) |=> shiftIn[0] == $past(cfg.sdi))
    else $error("serial bit not taken on rising edge");
  AST_NO_PULL_IDLE: assert property (@(posedge clk) disable iff (!resetn)
    !active |=> !sdoPull)
    else $error("data-out pulled while port idle");

endmodule

// File: test/acp_host_model.sv
/*
  Host model: sends 16-bit frames on the select, clock and data-in pins
  and gathers readback bits. Assumes the bench resolves data-out through
  its pull-up and that requests are taken on the rising clock edge.
*/
`timescale 1ns/1ps
module acp_host_model (
  // Clock
  input  wire logic        clk,
  // Request
  input  wire logic        go,
  input  wire logic        noSel,
  input  wire logic [15:0] frame,
  output logic             busy,
  output logic [7:0]       rdData,
  // Pins
  output logic             csN,
  output logic             sck,
  output logic             sdi,
  input  wire logic        sdoWire
);
  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  // Serial clock stands low between frames; half period is 4 clk
  initial begin
    busy = 1'b0;
    csN = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rdData = 8'h00;
    forever begin
      @(posedge clk);
      if (go) begin
        @(negedge clk);
        busy = 1'b1;
        csN = noSel;
        for (int i = 0; i < 16; i++) begin
          sdi = frame[15 - i];
          repeat (4) @(negedge clk);
          sck = 1'b1;
          repeat (4) @(negedge clk);
          sck = 1'b0;
          if (i >= 8) rdData = {rdData[6:0], sdoWire};
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        sdi = ~sdi; // Released line must not look valid
        repeat (6) @(negedge clk);
        busy = 1'b0;
      end
    end
  end
endmodule

// File: test/acp_port_top_tb.sv
/*
  Bench for the converter port: serial and parallel setup, readback,
  output word timing. Assumes the host model and the design files.
*/
`timescale 1ns/1ps
module acp_port_top_tb;
  logic        clk, resetn, configPathStrap, parCs, parSck, parSdi;
  logic        go, noSel, encPos, coreOverRange, chkOn, busy;
  logic        hostCs, hostSck, hostSdi, sdoOut, sdoOeN, sdoWire;
  logic        rangeFlag, fwdPos, fwdNeg, stabilizerOn, sleepMode;
  logic        lvdsHighDrive, csN, sck, sdi;
  logic [1:0]  outputMode;
  logic [7:0]  rdData, st;
  logic [13:0] coreWord, sampleBits, w;
  logic [15:0] frame;
  int          badCount, testsRun, encCount, encTick, k;

  // Parallel levels or host frames; data-out has a pull-up
  assign csN = configPathStrap ? parCs : hostCs;
  assign sck = configPathStrap ? parSck : hostSck;
  assign sdi = configPathStrap ? parSdi : hostSdi;
  assign sdoWire = sdoOeN ? 1'b1 : sdoOut;
  assign st = {3'h0, lvdsHighDrive, stabilizerOn, sleepMode, outputMode};

  acp_port_top dut_u (.clk(clk), .resetn(resetn),
    .configPathStrap(configPathStrap), .csN(csN), .sck(sck), .sdi(sdi),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .sampleClockPos(encPos),
    .sampleClockNeg(~encPos), .coreWord(coreWord),
    .coreOverRange(coreOverRange), .sampleBits(sampleBits),
    .rangeFlag(rangeFlag), .fwdOutClockPos(fwdPos),
    .fwdOutClockNeg(fwdNeg), .stabilizerOn(stabilizerOn),
    .sleepMode(sleepMode), .outputMode(outputMode),
    .lvdsHighDrive(lvdsHighDrive));

  acp_host_model host_u (.clk(clk), .go(go), .noSel(noSel),
    .frame(frame), .busy(busy), .rdData(rdData), .csN(hostCs),
    .sck(hostSck), .sdi(hostSdi), .sdoWire(sdoWire));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [13:0] wordOf(int n);
    return 14'(n * 32'h0A5B + 32'h1234);
  endfunction

  // Double-rate lane view of a word, odd or even half
  function automatic logic [13:0] lanes(logic [13:0] v, int odd);
    lanes = 14'h0000;
    for (int i = 0; i < 7; i++) lanes[i] = v[2 * i + odd];
  endfunction

  task automatic closeOut();
    if (badCount == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic checkBit(logic got, logic exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkByte(logic [7:0] got, logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkWord(logic [13:0] got, logic [13:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One serial frame; bounded waits on the host handshake
  task automatic xfer(logic rd, logic [6:0] a, logic [7:0] d, logic ns);
    int n;
    n = 0;
    @(negedge clk);
    frame = {rd, a, d};
    noSel = ns;
    go = 1'b1;
    while (busy !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    go = 1'b0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      badCount++;
      closeOut();
    end
    repeat (2) @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // Clock, encode source and output watchers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Encode at 800 ns; a fresh word and range bit at each rising edge
  always @(negedge clk) begin
    encTick <= (encTick == 3) ? 0 : encTick + 1;
    if (encTick == 3) begin
      encPos <= ~encPos;
      if (!encPos) begin
        encCount <= encCount + 1;
        coreWord <= wordOf(encCount + 1);
        coreOverRange <= ((encCount + 1) % 3) == 0;
      end
    end
  end

  always @(negedge clk) if (resetn === 1'b1) checkBit(fwdNeg, ~fwdPos);

  // Sample mid-way through each forwarded clock half
  always @(fwdPos) begin
    logic hi;
    hi = fwdPos;
    repeat (2) @(negedge clk);
    if (chkOn && encCount > 8) begin
      if (outputMode === 2'h0) begin
        if (hi) begin
          checkWord(sampleBits, wordOf(encCount - 5));
          checkBit(rangeFlag, ((encCount - 5) % 3) == 0);
        end
      end else begin
        w = wordOf(encCount - (hi ? 6 : 5));
        checkWord(sampleBits, lanes(w, int'(hi)));
        checkBit(rangeFlag, ((encCount - (hi ? 6 : 5)) % 3) == 0);
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {resetn, configPathStrap, parCs, parSck, parSdi} = 5'h00;
    {go, noSel, encPos, coreOverRange, chkOn} = 5'h00;
    frame = 16'h0000;
    coreWord = 14'h0000;
    badCount = 0;
    testsRun = 0;
    encCount = 0;
    encTick = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    checkByte(st, 8'h00);
    checkBit(sdoOeN, 1'b1);
    xfer(1'b0, 7'h03, 8'h12, 1'b0);
    checkByte(st, 8'h12);
    xfer(1'b0, 7'h02, 8'h01, 1'b0);
    checkByte(st, 8'h1A);
    xfer(1'b0, 7'h01, 8'h01, 1'b0);
    checkByte(st, 8'h1E);
    repeat (20) @(negedge clk);
    checkWord(sampleBits, 14'h0000);
    checkBit(fwdPos, 1'b0);
    xfer(1'b0, 7'h01, 8'h00, 1'b0);
    xfer(1'b0, 7'h03, 8'h00, 1'b1);
    checkByte(st, 8'h1A);
    xfer(1'b1, 7'h03, 8'h00, 1'b0);
    checkByte(rdData, 8'h12);
    xfer(1'b1, 7'h02, 8'h00, 1'b0);
    checkByte(rdData, 8'h01);
    xfer(1'b1, 7'h10, 8'h00, 1'b0);
    checkByte(rdData, 8'hFF);
    xfer(1'b0, 7'h00, 8'h80, 1'b0);
    checkByte(st, 8'h00);
    // Every output mode, pipeline settled before checking
    for (int m = 0; m < 3; m++) begin
      xfer(1'b0, 7'h03, 8'(m), 1'b0);
      repeat (60) @(negedge clk);
      chkOn = 1'b1;
      repeat (100) @(negedge clk);
      chkOn = 1'b0;
    end
    xfer(1'b0, 7'h03, 8'h00, 1'b0);
    // Forwarded clock falls p cycles after the data changes
    for (int p = 0; p < 4; p++) begin
      xfer(1'b0, 7'h02, 8'(p * 2), 1'b0);
      repeat (60) @(negedge clk);
      w = sampleBits;
      k = 0;
      while (sampleBits === w && k < 20) begin
        @(posedge clk);
        #1;
        k++;
      end
      // A word that never moves is a hang, not a pass
      if (k >= 20) begin
        badCount++;
        closeOut();
      end
      k = 0;
      while (fwdPos !== 1'b0 && k < 10) begin
        @(posedge clk);
        #1;
        k++;
      end
      if (k >= 10) begin
        badCount++;
        closeOut();
      end
      checkByte(8'(k), 8'(p));
    end
    // Parallel strap: pins are plain levels, data-out left alone
    @(negedge clk);
    configPathStrap = 1'b1;
    for (int c = 0; c < 8; c++) begin
      {parSdi, parSck, parCs} = 3'(c);
      repeat (10) @(negedge clk);
      checkByte(st, {3'h0, parSck, parCs, parSdi, parSck, 1'b0});
      checkBit(sdoOeN, 1'b1);
    end
    closeOut();
  end
endmodule
